// [rtl/cca_map.svh]
/*
  Register offsets, field positions and reset values for the counter
  array. Assumes a Wishbone slave with 32-bit data and byte addresses.
*/
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH
`define CCA_ADR_CTRL 8'h00
`define CCA_ADR_CNT 8'h04
`define CCA_ADR_MOD0 8'h10
`define CCA_ADR_CMP0 8'h14
`define CCA_ADR_CAP0 8'h18
`define CCA_ADR_WDKICK 8'h1C
`define CCA_MOD_STRIDE 8'h10
`define CCA_ADR_STATUS 8'h40
`define CCA_CTRL_RUN 0
`define CCA_CTRL_SEL_LO 1
`define CCA_CTRL_SEL_HI 3
`define CCA_MOD_MODE_LO 0
`define CCA_MOD_MODE_HI 2
`define CCA_MOD_POS 3
`define CCA_MOD_NEG 4
`define CCA_DIV12 4'hC
`define CCA_DIV4 4'h4
`define CCA_DIV8 4'h8
`define CCA_PWM8_TOP 8'hFF
`define CCA_PWM16_TOP 16'hFFFF
`define CCA_CTRL_RST 32'h0000_0001
`define CCA_MOD2_RST 32'h0000_0006
`define CCA_CMP2_RST 32'h0000_FFFF
`endif

// [rtl/cca_pkg.sv]
/*
  Types shared by the counter array files.
  Assumes cca_map.svh for all numeric constants.
*/
package cca_pkg;
  typedef enum logic [2:0] {
    CCA_CAPTURE, CCA_SWTIMER, CCA_HSOUT, CCA_PWM8,
    CCA_PWM16, CCA_FREQ, CCA_WATCHDOG, CCA_OFF
  } cca_mode_t;
  typedef enum logic [2:0] {
    CCA_SRC_DIV12, CCA_SRC_DIV4, CCA_SRC_T0, CCA_SRC_ECI,
    CCA_SRC_SYS, CCA_SRC_XOSC8, CCA_SRC_R6, CCA_SRC_R7
  } cca_src_t;
  typedef struct packed {
    logic [2:0] cap_in;
    logic ext_count;
    logic ext_osc;
    logic t0_ovf;
  } cca_pins_t;
endpackage

// [rtl/cca_top.sv]
/*
  Counter array with shared 16-bit time base and three capture/compare
  modules, reached over classic Wishbone.
  Assumes crossbar routes module pins and the count input; pins are
  asynchronous and synchronised here.
*/
// Added by the designer: register access over Wishbone and the address map.
// What this block does
// RQ1: The time base tick is chosen from sysclk/12, sysclk/4, timer 0 overflow, the external count input, sysclk, or external oscillator/8.
// RQ2: One 16-bit counter is the common time base of exactly three modules.
// RQ3: Each module runs independently as capture, timer, high speed output, 8-bit PWM, 16-bit PWM or frequency output.
// RQ4: Module 2 alone can also act as a watchdog.
// RQ5: After reset module 2 is already a running watchdog.
// RQ6: Module pins and the count input only reach the outside through the crossbar.
// RQ7: The counter advances once per selected tick, asynchronous sources synchronised first.
`timescale 1ns/1ps
`include "cca_map.svh"
module cca_top #(
  parameter int NMOD = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cca_pkg::cca_pins_t pins_i,
  output logic [2:0] cex_o,
  output logic wdt_reset_o
);
  import cca_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detectors.
  // Only the second stage feeds logic; the third is edge history.
  cca_pins_t sync1_ff, sync2_ff, sync3_ff;
  cca_pins_t nxt_sync1, nxt_sync2, nxt_sync3;
  cca_pins_t rise, fall;

  always_comb begin
    nxt_sync1 = pins_i; // [RQ7]
    nxt_sync2 = sync1_ff;
    nxt_sync3 = sync2_ff;
    rise = cca_pins_t'(sync2_ff & ~sync3_ff);
    fall = cca_pins_t'(~sync2_ff & sync3_ff);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      sync3_ff <= nxt_sync3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State of the time base, the modules and the bus.
  localparam int WD_MOD = 2;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [3:0] d12_ff, nxt_d12;
  logic [3:0] d4_ff, nxt_d4;
  logic [3:0] d8_ff, nxt_d8;
  logic [31:0] mod_ff [NMOD];
  logic [31:0] nxt_mod [NMOD];
  logic [15:0] cmp_ff [NMOD];
  logic [15:0] nxt_cmp [NMOD];
  logic [15:0] cap_ff [NMOD];
  logic [15:0] nxt_cap [NMOD];
  logic [NMOD-1:0] cex_ff, nxt_cex;
  logic [NMOD-1:0] flag_ff, nxt_flag;
  logic wdr_ff, nxt_wdr;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [31:0] rdata;
  logic tick;
  logic wr;
  logic rd;
  cca_src_t src;
  cca_mode_t md [NMOD];
  logic [NMOD-1:0] pe;
  logic [NMOD-1:0] hitc;

  function automatic logic [31:0] mrg(input logic [31:0] o,
                                      input logic [31:0] n,
                                      input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      mrg[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r,
                               input int m);
    hit = a == 8'(r + 8'(m) * `CCA_MOD_STRIDE);
  endfunction

  function automatic cca_mode_t mode_of(input logic [31:0] r);
    mode_of = cca_mode_t'(r[`CCA_MOD_MODE_HI:`CCA_MOD_MODE_LO]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake and read data.
  always_comb begin
    // Ack is a registered pulse, so a held request is taken once every two cycles.
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_dat = rd ? rdata : 32'h0;
  end

  always_comb begin
    rdata = 32'h0;
    if (wb_adr_i == `CCA_ADR_CTRL) rdata = ctrl_ff;
    if (wb_adr_i == `CCA_ADR_CNT) rdata = {16'h0, cnt_ff};
    if (wb_adr_i == `CCA_ADR_STATUS) rdata = 32'(flag_ff);
    for (int m = 0; m < NMOD; m++) begin
      if (hit(wb_adr_i, `CCA_ADR_MOD0, m)) rdata = mod_ff[m];
      if (hit(wb_adr_i, `CCA_ADR_CMP0, m)) rdata = {16'h0, cmp_ff[m]};
      if (hit(wb_adr_i, `CCA_ADR_CAP0, m)) rdata = {16'h0, cap_ff[m]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base and its clock selection.
  always_comb begin
    src = cca_src_t'(ctrl_ff[`CCA_CTRL_SEL_HI:`CCA_CTRL_SEL_LO]);
    nxt_d12 = (d12_ff == `CCA_DIV12 - 4'h1) ? 4'h0 : d12_ff + 4'h1;
    nxt_d4 = (d4_ff == `CCA_DIV4 - 4'h1) ? 4'h0 : d4_ff + 4'h1;
    nxt_d8 = d8_ff;
    // The oscillator prescaler counts oscillator edges, not system clocks.
    if (rise.ext_osc) begin
      nxt_d8 = (d8_ff == `CCA_DIV8 - 4'h1) ? 4'h0 : d8_ff + 4'h1;
    end
    unique case (src) // [RQ1]
      CCA_SRC_DIV12: tick = d12_ff == 4'h0;
      CCA_SRC_DIV4: tick = d4_ff == 4'h0;
      CCA_SRC_T0: tick = rise.t0_ovf;
      CCA_SRC_ECI: tick = rise.ext_count;
      CCA_SRC_SYS: tick = 1'b1;
      CCA_SRC_XOSC8: tick = rise.ext_osc && d8_ff == `CCA_DIV8 - 4'h1;
      default: tick = 1'b0;
    endcase
    tick = tick && ctrl_ff[`CCA_CTRL_RUN];
    nxt_ctrl = ctrl_ff;
    nxt_cnt = tick ? cnt_ff + 16'h1 : cnt_ff; // [RQ2] [RQ7]
    if (wr && wb_adr_i == `CCA_ADR_CTRL) begin
      nxt_ctrl = mrg(ctrl_ff, wb_dat_i, wb_sel_i);
    end
    // A counter write wins over a tick in the same cycle.
    if (wr && wb_adr_i == `CCA_ADR_CNT) begin
      nxt_cnt = 16'(mrg({16'h0, cnt_ff}, wb_dat_i, wb_sel_i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `CCA_CTRL_RST;
      cnt_ff <= 16'h0;
      d12_ff <= 4'h0;
      d4_ff <= 4'h0;
      d8_ff <= 4'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cnt_ff <= nxt_cnt;
      d12_ff <= nxt_d12;
      d4_ff <= nxt_d4;
      d8_ff <= nxt_d8;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture/compare modules.
  always_comb begin
    for (int m = 0; m < NMOD; m++) begin
      md[m] = mode_of(mod_ff[m]);
      pe[m] = (mod_ff[m][`CCA_MOD_POS] && rise.cap_in[m]) ||
              (mod_ff[m][`CCA_MOD_NEG] && fall.cap_in[m]);
      // Eight-bit modulation compares only the low counter byte.
      if (md[m] == CCA_PWM8) begin
        hitc[m] = tick && cnt_ff[7:0] == cmp_ff[m][7:0];
      end else begin
        hitc[m] = tick && cnt_ff == cmp_ff[m];
      end
    end
  end

  always_comb begin
    nxt_wdr = 1'b0;
    for (int m = 0; m < NMOD; m++) begin
      nxt_mod[m] = mod_ff[m];
      nxt_cmp[m] = cmp_ff[m];
      nxt_cap[m] = cap_ff[m];
      nxt_cex[m] = cex_ff[m];
      nxt_flag[m] = flag_ff[m];
      // The clear comes first, so an event in the same cycle wins.
      if (wr && wb_adr_i == `CCA_ADR_STATUS && wb_sel_i[0] &&
          wb_dat_i[m]) begin
        nxt_flag[m] = 1'b0;
      end
      if (wr && hit(wb_adr_i, `CCA_ADR_MOD0, m)) begin
        nxt_mod[m] = mrg(mod_ff[m], wb_dat_i, wb_sel_i); // [RQ3]
        // Watchdog code is refused on modules without it.
        if (m != WD_MOD && mode_of(nxt_mod[m]) == CCA_WATCHDOG) begin
          nxt_mod[m] = mod_ff[m]; // [RQ4]
        end
      end
      if (wr && hit(wb_adr_i, `CCA_ADR_CMP0, m)) begin
        nxt_cmp[m] = 16'(mrg({16'h0, cmp_ff[m]}, wb_dat_i, wb_sel_i));
      end
      unique case (md[m]) // [RQ3]
        CCA_CAPTURE: begin
          if (pe[m]) begin
            nxt_cap[m] = cnt_ff;
            nxt_flag[m] = 1'b1;
          end
        end
        CCA_SWTIMER: begin
          if (hitc[m]) nxt_flag[m] = 1'b1;
        end
        CCA_HSOUT: begin
          if (hitc[m]) begin
            nxt_cex[m] = ~cex_ff[m];
            nxt_flag[m] = 1'b1;
          end
        end
        CCA_PWM8: begin
          if (hitc[m]) nxt_cex[m] = 1'b1;
          if (tick && cnt_ff[7:0] == `CCA_PWM8_TOP) nxt_cex[m] = 1'b0;
        end
        CCA_PWM16: begin
          if (hitc[m]) nxt_cex[m] = 1'b1;
          if (tick && cnt_ff == `CCA_PWM16_TOP) nxt_cex[m] = 1'b0;
        end
        CCA_FREQ: begin
          // The high compare byte is added to the low compare byte at each full 16-bit match.
          if (hitc[m]) begin
            nxt_cex[m] = ~cex_ff[m];
            nxt_cmp[m][7:0] = cmp_ff[m][7:0] + cmp_ff[m][15:8];
          end
        end
        CCA_WATCHDOG: begin // [RQ4]
          // A kick in the match cycle moves the deadline and wins.
          if (wr && hit(wb_adr_i, `CCA_ADR_WDKICK, m)) begin
            nxt_cmp[m] = cnt_ff + wb_dat_i[15:0];
          end else if (hitc[m]) begin
            nxt_wdr = 1'b1;
          end
        end
        CCA_OFF: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cex_ff <= '0;
      flag_ff <= '0;
      wdr_ff <= 1'b0;
      for (int m = 0; m < NMOD; m++) begin
        mod_ff[m] <= (m == WD_MOD) ? `CCA_MOD2_RST : 32'h0; // [RQ5]
        cmp_ff[m] <= (m == WD_MOD) ? 16'(`CCA_CMP2_RST) : 16'h0;
        cap_ff[m] <= 16'h0;
      end
    end else begin
      cex_ff <= nxt_cex;
      flag_ff <= nxt_flag;
      wdr_ff <= nxt_wdr;
      mod_ff <= nxt_mod;
      cmp_ff <= nxt_cmp;
      cap_ff <= nxt_cap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs go to the crossbar, never straight to pads.
  assign cex_o = cex_ff; // [RQ6]
  assign wdt_reset_o = wdr_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
endmodule // cca_top

// [test/cca_top_chk.sv]
/* Port timing checker for cca_top.
   Assumes the bind below attaches it to every cca_top instance. */
`timescale 1ns/1ps
module cca_top_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] cex_o,
  input wire logic wdt_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_ack)
    else $error("ack not a single cycle after request");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_wr_no_data: assert property (wb_ack_o && $past(wb_we_i) |->
    wb_dat_o == 32'h0000_0000)
    else $error("write ack carries read data");
  a_wdt_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("watchdog reset longer than one cycle");
  a_quiet_exit: assert property ($fell(rst_i) |->
    !wb_ack_o && !wdt_reset_o && cex_o == 3'h0)
    else $error("outputs active right after reset");
endmodule // cca_top_chk
////////////////////////////////////////////////////////////////////////////
bind cca_top cca_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cex_o(cex_o), .wdt_reset_o(wdt_reset_o));

// [test/tb_top.sv]
/* Self-checking bench for cca_top over classic Wishbone.
   Assumes pins_i follows the packed pin struct: module pins at bits 5:3,
   count input bit 2, oscillator bit 1, timer 0 overflow bit 0. */
`timescale 1ns/1ps
`include "cca_map.svh"
module tb_top;
  import cca_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wdt_reset_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, a, b;
  logic [2:0] cex_o;
  logic [15:0] d;
  cca_pins_t pins_i;
  int n_mismatch = 0;
  int tests_run = 0;
  int e, n;
  int src[6] = '{4, 1, 0, 3, 2, 5};
  int dv[6] = '{1, 4, 12, 1, 1, 8};
  int pb[6] = '{0, 0, 0, 4, 1, 2};
  cca_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pins_i(pins_i), .cex_o(cex_o),
    .wdt_reset_o(wdt_reset_o));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is sampled; a dead slave trips the limit.
  task automatic xfer(input logic we, input logic [7:0] ad,
                      input logic [31:0] dw, output logic [31:0] dr);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= dw;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    dr = wb_dat_o;
    chk(32'(k < 50), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int bn);
    pins_i <= cca_pins_t'(6'(bn));
    repeat (4) @(posedge clk_i);
    pins_i <= cca_pins_t'(6'h00);
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'hF;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    pins_i = cca_pins_t'(6'h00);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    xfer(1'b0, `CCA_ADR_CTRL, 32'h0, q);
    chk(q, `CCA_CTRL_RST);
    xfer(1'b0, `CCA_ADR_MOD0 + 8'h20, 32'h0, q);
    chk(q, `CCA_MOD2_RST);
    xfer(1'b0, `CCA_ADR_CMP0 + 8'h20, 32'h0, q);
    chk(q, `CCA_CMP2_RST);
    xfer(1'b0, 8'hFC, 32'h0, q);
    chk(q, 32'h0);
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 6; c++) begin
        xfer(1'b1, `CCA_ADR_MOD0 + 8'(16 * m), 32'(c), q);
        xfer(1'b0, `CCA_ADR_MOD0 + 8'(16 * m), 32'h0, q);
        chk(q, 32'(c));
      end
    end
    xfer(1'b1, `CCA_ADR_MOD0, 32'h6, q);
    xfer(1'b0, `CCA_ADR_MOD0, 32'h0, q);
    chk(q, 32'h5);
    xfer(1'b1, `CCA_ADR_MOD0 + 8'h20, 32'h6, q);
    xfer(1'b0, `CCA_ADR_MOD0 + 8'h20, 32'h0, q);
    chk(q, 32'h6);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, `CCA_ADR_CTRL, 32'(src[i] * 2 + 1), q);
      xfer(1'b0, `CCA_ADR_CNT, 32'h0, a);
      if (pb[i] == 0) repeat (240) @(posedge clk_i);
      else repeat (16) pulse(pb[i]);
      xfer(1'b0, `CCA_ADR_CNT, 32'h0, b);
      d = b[15:0] - a[15:0];
      e = (pb[i] == 0 ? 243 : 16) / dv[i];
      chk(32'(d + 1 >= e && d <= e + 1), 32'h1);
    end
    xfer(1'b1, `CCA_ADR_CTRL, 32'h9, q);
    xfer(1'b1, `CCA_ADR_WDKICK + 8'h20, 32'h64, q);
    n = 0;
    while (wdt_reset_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n > 80 && n < 120), 32'h1);
    xfer(1'b1, `CCA_ADR_MOD0, 32'h8, q);
    pulse(32'h08);
    xfer(1'b0, `CCA_ADR_STATUS, 32'h0, q);
    chk(q & 32'h1, 32'h1);
    xfer(1'b1, `CCA_ADR_STATUS, 32'h1, q);
    xfer(1'b0, `CCA_ADR_STATUS, 32'h0, q);
    chk(q & 32'h1, 32'h0);
    xfer(1'b1, `CCA_ADR_MOD0 + 8'h10, 32'h2, q);
    xfer(1'b0, `CCA_ADR_CNT, 32'h0, a);
    xfer(1'b1, `CCA_ADR_CMP0 + 8'h10, a + 32'h28, q);
    b = {29'h0, cex_o};
    n = 0;
    while (cex_o[1] === b[1] && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n > 20 && n < 60), 32'h1);
    xfer(1'b0, `CCA_ADR_STATUS, 32'h0, q);
    chk(q & 32'h2, 32'h2);
    print_verdict();
  end
endmodule // tb_top
